/* core/rsc_pkg.sv */
`default_nettype none
package rsc_pkg;
   // Register byte addresses
   localparam logic [7:0] RSC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] RSC_ADDR_NOMINAL = 8'h04;
   localparam logic [7:0] RSC_ADDR_UPPER = 8'h08;
   localparam logic [7:0] RSC_ADDR_LOWER = 8'h0c;
   localparam logic [7:0] RSC_ADDR_STATUS = 8'h10;
   localparam logic [7:0] RSC_ADDR_REF = 8'h14;
   localparam logic [7:0] RSC_ADDR_CMD = 8'h18;
   localparam logic [7:0] RSC_ADDR_TEL = 8'h20;
   localparam logic [7:0] RSC_ADDR_PEAK = 8'h40;
   localparam logic [7:0] RSC_PEAK_WIPE_CODE = 8'he3;
   // Control field positions
   localparam int RSC_CTRL_ON = 0;
   localparam logic RSC_ON_RESET = 1'b1;
   localparam logic [8:0] RSC_OFFSET_RESET = 9'h000;
   localparam logic [8:0] RSC_OFFSET_MAX = 9'h0fa;
   localparam logic [8:0] RSC_OFFSET_MIN = 9'h106;
   // Telemetry channel indices
   localparam int RSC_CH_VIN = 0;
   localparam int RSC_CH_VOUT = 1;
   localparam int RSC_CH_IIN = 2;
   localparam int RSC_CH_IOUT = 3;
   localparam int RSC_CH_TEMP = 4;
   localparam int RSC_NCH = 5;
   // Timing
   localparam int RSC_CLK_HZ = 100_000_000;
   localparam int RSC_FAST_HZ = 25;
   localparam int RSC_SLOW_HZ = 1;
   localparam int RSC_FAST_CYC = RSC_CLK_HZ / RSC_FAST_HZ;
   localparam int RSC_SLOW_CYC = RSC_CLK_HZ / RSC_SLOW_HZ;
   localparam int RSC_BLANK_SW_CYC = 16;
   localparam int RSC_PG_MAX_MS = 25;
   localparam int RSC_PG_MAX_CYC = RSC_PG_MAX_MS * (RSC_CLK_HZ / 1000);
   localparam int RSC_SYNC_TIMEOUT = 64;
   typedef enum logic [1:0] {RSC_MG_LOW, RSC_MG_NOM, RSC_MG_HIGH} rsc_margin_t;
   typedef enum logic [1:0] {RSC_MST_OFF, RSC_MST_STBY, RSC_MST_RUN} rsc_mode_t;
   typedef struct packed {
      logic ov;
      logic uv;
      logic win_ok;
      logic track_below;
   } rsc_cmp_t;
endpackage
`default_nettype wire

/* core/rsc_mem.sv */
`default_nettype none
module rsc_mem #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 13
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Read port
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   initial begin
      if (DEPTH < 2) $error("rsc_mem depth too small");
   end
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

/* core/rsc_top.sv */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
// What this block does
// R1: Signed 9-bit offset drives the reference converter, 0.1 percent per code.
// R2: Reference steps one code toward target per slew tick.
// R3: Nominal, upper and lower offsets held, margin pin selects one.
// R4: Write-protect high blocks writes to the three offsets.
// R5: Five 13-bit readings refreshed at 25 Hz, readable over bus.
// R6: Each reading has a peak register with highest value since restart.
// R7: Peaks restart on wipe command, peak write, or master run low.
// R8: Track below reference selects tracking, else the reference.
// R9: Discontinuous mode while tracking voltage is below reference.
// R10: Window pin tied high selects the default plus/minus 10 percent window.
// R11: Valid flag rise delayed by delay-pin count, at most 25 ms.
// R12: Valid flag fall blanked for 16 switching cycles.
// R13: Forced continuous during OV or UV, except while tracking.
// R14: Master run low stops switching, control, converter and bus.
// R15: Master shutdown returns written registers to power-on values.
// R16: Standby stops regulation, bus stays, telemetry refresh 1 Hz.
// R17: Standby refreshes only input voltage, output voltage, temperature.
// R18: Rising on-bit clears faults and releases alert.
// R19: Standby keeps all written registers.
// R20: Switching needs master run, standby run and on-bit all high.
// R21: On-bit set at power-on and master shutdown.
// R22: Detected external sync clock selects external clock source.
// R23: Nominal offset is two's complement, zero after power-up.
// R24: Wipe command code clears all peaks, data ignored.
// R25: Margin pin decoded continuously, 00 lower, 11 upper, 01 and 10 both nominal.
module rsc_top
   import rsc_pkg::*;
#(
   parameter int FAST_CYC = RSC_FAST_CYC,
   parameter int SLOW_CYC = RSC_SLOW_CYC,
   parameter int PG_MAX_CYC = RSC_PG_MAX_CYC,
   parameter int TW = 13
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic master_run_pin,
   input wire logic standby_run_pin,
   input wire logic write_protect_pin,
   input wire logic [1:0] margin_pin,
   input wire logic valid_window_pin,
   input wire logic [23:0] valid_delay_pin,
   input wire logic sync_pin,
   input wire logic slew_tick,
   input wire logic sw_cycle,
   input wire rsc_cmp_t cmp,
   // Converter interface
   input wire logic adc_done,
   input wire logic [TW-1:0] adc_data,
   output logic [2:0] adc_chan,
   output logic adc_start,
   // Outputs
   output logic [8:0] ref_dac,
   output logic switch_en,
   output logic disc_mode,
   output logic track_sel,
   output logic pg_default_win,
   output logic ext_clk_sel,
   output logic output_valid_flag,
   output logic alert_n,
   output logic fault_flag
);
   initial begin
      if (TW != 13 || FAST_CYC < 2 || SLOW_CYC < FAST_CYC) $error("bad params");
   end
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int NS = 13;
   logic [NS-1:0] s1_r, s2_r;
   wire logic [NS-1:0] raw = {master_run_pin, standby_run_pin,
      write_protect_pin, margin_pin, valid_window_pin, sync_pin, slew_tick,
      sw_cycle, cmp};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
      end
   end
   wire logic mrun = s2_r[12];
   wire logic srun = s2_r[11];
   wire logic wp = s2_r[10];
   wire logic [1:0] mpin = s2_r[9:8];
   wire logic win_tied = s2_r[7];
   wire logic sync_s = s2_r[6];
   wire logic slew_s = s2_r[5];
   wire logic swc_s = s2_r[4];
   wire rsc_cmp_t cmp_s = rsc_cmp_t'(s2_r[3:0]);
   logic slew_d_r, swc_d_r, sync_d_r, mrun_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slew_d_r <= 1'b0;
         swc_d_r <= 1'b0;
         sync_d_r <= 1'b0;
         mrun_d_r <= 1'b0;
      end else begin
         slew_d_r <= slew_s;
         swc_d_r <= swc_s;
         sync_d_r <= sync_s;
         mrun_d_r <= mrun;
      end
   end
   wire logic slew_edge = slew_s & ~slew_d_r;
   wire logic swc_edge = swc_s & ~swc_d_r;
   wire logic sync_edge = sync_s & ~sync_d_r;
   wire logic mst_off = ~mrun; // [R14]
   wire logic mrun_fall = mrun_d_r & ~mrun;
   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   function automatic logic is_tel(input logic [7:0] a, input logic [7:0] b);
      return (a >= b) && (a < b + 8'(4 * RSC_NCH)) && (a[1:0] == 2'b00);
   endfunction
   wire logic acc = psel & penable & pready & ~mst_off;
   wire logic wr = acc & pwrite;
   wire logic [2:0] tidx = 3'(paddr[4:2]);
   logic on_r, on_d_r;
   logic [8:0] nom_r, up_r, lo_r;
   wire logic off_wr_ok = wr & ~wp; // [R4]
   // Registers clear on master shutdown, kept in standby
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_r <= RSC_ON_RESET; // [R21]
         nom_r <= RSC_OFFSET_RESET; // [R23]
         up_r <= RSC_OFFSET_RESET;
         lo_r <= RSC_OFFSET_RESET;
      end else if (mst_off) begin
         on_r <= RSC_ON_RESET; // [R15] [R21]
         nom_r <= RSC_OFFSET_RESET; // [R15]
         up_r <= RSC_OFFSET_RESET;
         lo_r <= RSC_OFFSET_RESET;
      end else begin // [R19]
         if (wr && paddr == RSC_ADDR_CTRL) begin
            on_r <= pwdata[RSC_CTRL_ON];
         end
         if (off_wr_ok && paddr == RSC_ADDR_NOMINAL) begin
            nom_r <= clamp(pwdata[8:0]); // [R23]
         end
         if (off_wr_ok && paddr == RSC_ADDR_UPPER) begin
            up_r <= clamp(pwdata[8:0]); // [R3]
         end
         if (off_wr_ok && paddr == RSC_ADDR_LOWER) begin
            lo_r <= clamp(pwdata[8:0]); // [R3]
         end
      end
   end
   function automatic logic [8:0] clamp(input logic [8:0] v);
      if (!v[8] && v > RSC_OFFSET_MAX) return RSC_OFFSET_MAX;
      else if (v[8] && v < RSC_OFFSET_MIN) return RSC_OFFSET_MIN;
      else return v;
   endfunction
   // ------------------------------------------------------------
   // Margin select and reference ramp
   // ------------------------------------------------------------
   logic [8:0] target;
   always_comb begin
      case (mpin) // [R25]
         2'b00: target = lo_r; // [R3]
         2'b11: target = up_r;
         default: target = nom_r;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_dac <= RSC_OFFSET_RESET;
      end else if (mst_off) begin
         ref_dac <= RSC_OFFSET_RESET;
      end else if (slew_edge && ref_dac != target) begin
         if ($signed(target) > $signed(ref_dac)) begin
            ref_dac <= ref_dac + 9'h001; // [R1] [R2]
         end else begin
            ref_dac <= ref_dac - 9'h001; // [R2]
         end
      end
   end
   // ------------------------------------------------------------
   // Operating state
   // ------------------------------------------------------------
   rsc_mode_t mode_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= RSC_MST_OFF;
      end else begin
         case (1'b1)
            mst_off: mode_r <= RSC_MST_OFF; // [R20]
            (srun && on_r): mode_r <= RSC_MST_RUN; // [R20]
            default: mode_r <= RSC_MST_STBY; // [R16]
         endcase
      end
   end
   wire logic run = (mode_r == RSC_MST_RUN);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_en <= 1'b0;
         track_sel <= 1'b0;
         disc_mode <= 1'b0;
         pg_default_win <= 1'b0;
      end else begin
         switch_en <= run; // [R14] [R20]
         track_sel <= run & cmp_s.track_below; // [R8]
         // Forced continuous on OV/UV unless still tracking
         disc_mode <= run & (cmp_s.track_below |
            ~(cmp_s.ov | cmp_s.uv)); // [R9] [R13]
         pg_default_win <= win_tied; // [R10]
      end
   end
   // ------------------------------------------------------------
   // External sync detection
   // ------------------------------------------------------------
   logic [6:0] sync_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_cnt_r <= '0;
         ext_clk_sel <= 1'b0;
      end else if (sync_edge) begin
         sync_cnt_r <= 7'(RSC_SYNC_TIMEOUT);
         ext_clk_sel <= 1'b1; // [R22]
      end else if (sync_cnt_r != 7'h00) begin
         sync_cnt_r <= sync_cnt_r - 7'h01;
      end else begin
         ext_clk_sel <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Output valid flag: delay on rise, blank on fall
   // ------------------------------------------------------------
   logic [23:0] pg_cnt_r;
   logic [4:0] blank_r;
   wire logic [23:0] dly = (valid_delay_pin > 24'(PG_MAX_CYC)) ?
      24'(PG_MAX_CYC) : valid_delay_pin;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_cnt_r <= '0;
         blank_r <= '0;
         output_valid_flag <= 1'b0;
      end else if (!run) begin
         pg_cnt_r <= '0;
         blank_r <= '0;
         output_valid_flag <= 1'b0;
      end else if (cmp_s.win_ok) begin
         blank_r <= '0;
         if (!output_valid_flag) begin
            if (pg_cnt_r >= dly) begin
               output_valid_flag <= 1'b1; // [R11]
            end else begin
               pg_cnt_r <= pg_cnt_r + 24'h000001;
            end
         end
      end else begin
         pg_cnt_r <= '0;
         if (output_valid_flag && swc_edge) begin
            if (blank_r == 5'(RSC_BLANK_SW_CYC - 1)) begin
               output_valid_flag <= 1'b0; // [R12]
            end else begin
               blank_r <= blank_r + 5'h01;
            end
         end
      end
   end
   // ------------------------------------------------------------
   // Faults and alert
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_d_r <= RSC_ON_RESET;
         fault_flag <= 1'b0;
         alert_n <= 1'b1;
      end else begin
         on_d_r <= on_r;
         if (run && (cmp_s.ov || cmp_s.uv)) begin
            fault_flag <= 1'b1;
            alert_n <= 1'b0;
         end else if (on_r && !on_d_r) begin
            fault_flag <= 1'b0; // [R18]
            alert_n <= 1'b1;
         end
      end
   end
   // ------------------------------------------------------------
   // Telemetry sequencer and peaks
   // ------------------------------------------------------------
   logic [26:0] rate_cnt_r;
   logic [2:0] ch_r;
   logic busy_r;
   logic [TW-1:0] peak_r [RSC_NCH];
   wire logic slow = (mode_r == RSC_MST_STBY); // [R16]
   wire logic [26:0] period = slow ? 27'(SLOW_CYC) : 27'(FAST_CYC);
   function automatic logic skip_ch(input logic [2:0] c, input logic s);
      return s && (c == 3'(RSC_CH_IIN) || c == 3'(RSC_CH_IOUT)); // [R17]
   endfunction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_cnt_r <= '0;
         ch_r <= '0;
         busy_r <= 1'b0;
         adc_start <= 1'b0;
         adc_chan <= 3'h7;
      end else if (mst_off) begin // [R14]
         adc_chan <= 3'h7;
         rate_cnt_r <= '0;
         ch_r <= '0;
         busy_r <= 1'b0;
         adc_start <= 1'b0;
      end else begin
         adc_start <= 1'b0;
         if (!busy_r) begin
            if (rate_cnt_r >= period - 27'd1) begin // [R5]
               rate_cnt_r <= '0;
               busy_r <= 1'b1;
               ch_r <= '0;
            end else begin
               rate_cnt_r <= rate_cnt_r + 27'd1;
            end
         end else if (ch_r == 3'(RSC_NCH)) begin
            busy_r <= 1'b0;
         end else if (skip_ch(ch_r, slow)) begin
            ch_r <= ch_r + 3'd1;
         end else if (!adc_start && adc_chan != ch_r) begin
            adc_chan <= ch_r;
            adc_start <= 1'b1;
         end else if (adc_done) begin
            ch_r <= ch_r + 3'd1;
            adc_chan <= 3'h7;
         end
      end
   end
   wire logic tel_we = busy_r & adc_done & ~mst_off & (adc_chan == ch_r);
   wire logic wipe = wr && paddr == RSC_ADDR_CMD &&
      pwdata[7:0] == RSC_PEAK_WIPE_CODE; // [R24]
   genvar g;
   generate
      for (g = 0; g < RSC_NCH; g++) begin : g_peak
         wire logic hit = wr && paddr == RSC_ADDR_PEAK + 8'(4 * g);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               peak_r[g] <= '0;
            end else if (mst_off || mrun_fall || wipe || hit) begin
               peak_r[g] <= '0; // [R7]
            end else if (tel_we && ch_r == 3'(g) && adc_data > peak_r[g]) begin
               peak_r[g] <= adc_data; // [R6]
            end
         end
      end
   endgenerate
   logic [TW-1:0] tel_rd;
   rsc_mem #(.DEPTH(8), .WIDTH(TW)) u_tel (
      .clk(pclk),
      .we(tel_we),
      .waddr(ch_r),
      .wdata(adc_data),
      .raddr(tidx),
      .rdata(tel_rd)
   );
   // ------------------------------------------------------------
   // APB response: two wait states so memory data is registered
   // ------------------------------------------------------------
   logic ph_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_r <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         if (psel && penable && !pready) begin
            ph_r <= ~ph_r;
            if (ph_r) begin
               pready <= 1'b1;
               ph_r <= 1'b0;
               prdata <= '0;
               if (mst_off) begin
                  pslverr <= 1'b1;
               end else if (paddr == RSC_ADDR_CTRL) begin
                  prdata <= {31'h0, on_r};
               end else if (paddr == RSC_ADDR_NOMINAL) begin
                  prdata <= {23'h0, nom_r};
               end else if (paddr == RSC_ADDR_UPPER) begin
                  prdata <= {23'h0, up_r};
               end else if (paddr == RSC_ADDR_LOWER) begin
                  prdata <= {23'h0, lo_r};
               end else if (paddr == RSC_ADDR_STATUS) begin
                  prdata <= {24'h0, mode_r, ext_clk_sel, fault_flag,
                     output_valid_flag, switch_en, disc_mode, track_sel};
               end else if (paddr == RSC_ADDR_REF) begin
                  prdata <= {23'h0, ref_dac};
               end else if (paddr == RSC_ADDR_CMD) begin
                  prdata <= '0;
               end else if (is_tel(paddr, RSC_ADDR_TEL)) begin
                  prdata <= {19'h0, tel_rd}; // [R5]
               end else if (is_tel(paddr, RSC_ADDR_PEAK)) begin
                  prdata <= {19'h0, peak_r[tidx]};
               end else begin
                  pslverr <= 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* tb/rsc_top_properties.sv */
`default_nettype none
module rsc_top_properties (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and outputs
   input wire logic master_run_pin,
   input wire logic standby_run_pin,
   input wire logic valid_window_pin,
   input wire logic sync_pin,
   input wire logic adc_start,
   input wire logic [2:0] adc_chan,
   input wire logic [8:0] ref_dac,
   input wire logic switch_en,
   input wire logic disc_mode,
   input wire logic track_sel,
   input wire logic pg_default_win,
   input wire logic ext_clk_sel
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sync_d_r;
   logic [7:0] quiet_r;
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----
   // Cycles since the sync line last moved
   // ----
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_d_r <= 1'b0;
         quiet_r <= 8'h00;
      end else begin
         sync_d_r <= sync_pin;
         if (sync_pin != sync_d_r)
            quiet_r <= 8'h00;
         else if (quiet_r != 8'hff)
            quiet_r <= quiet_r + 8'h01;
      end
   end
   a_bus_answer: assert property ($rose(penable) && psel |-> ##2 pready)
      else $error("pready late or missing");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (pready && paddr == 8'h1c |-> pslverr)
      else $error("unmapped access without error");
   a_adc_chan: assert property (adc_start |-> adc_chan <= 3'h4)
      else $error("converter channel out of range");
   a_ref_step: assert property (disable iff (!presetn || !master_run_pin)
      $changed(ref_dac) |-> ref_dac == $past(ref_dac) + 9'h001 ||
      ref_dac == $past(ref_dac) - 9'h001)
      else $error("reference moved by more than one code");
   a_master_off: assert property (!master_run_pin [*5] |->
      !switch_en && !adc_start)
      else $error("activity while master run low");
   a_standby_off: assert property (!standby_run_pin [*5] |-> !switch_en)
      else $error("switching while standby pin low");
   a_disc_track: assert property (track_sel |-> disc_mode)
      else $error("tracking outside discontinuous mode");
   a_window_dflt: assert property (valid_window_pin [*4] |-> pg_default_win)
      else $error("default window not selected");
   a_sync_quiet: assert property (quiet_r > 8'h50 |-> !ext_clk_sel)
      else $error("external clock kept without edges");
endmodule
bind rsc_top rsc_top_properties rsc_top_properties_inst (.pclk, .presetn,
   .psel, .penable, .paddr, .pready, .pslverr, .master_run_pin,
   .standby_run_pin, .valid_window_pin, .sync_pin, .adc_start, .adc_chan,
   .ref_dac, .switch_en, .disc_mode, .track_sel, .pg_default_win,
   .ext_clk_sel);
`default_nettype wire

/* tb/rsc_stage_model.sv */
`default_nettype none
module rsc_stage_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Converter side
   input wire logic adc_start,
   input wire logic [2:0] adc_chan,
   output logic adc_done,
   output logic [12:0] adc_data,
   // Bench controls
   input wire logic [9:0] lvl,
   input wire logic sync_on,
   output logic sync_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] chan_r;
   logic [1:0] wait_r;
   logic busy_r;
   // Result tagged with its channel, bus churns when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
         wait_r <= 2'h0;
         chan_r <= 3'h0;
         adc_done <= 1'b0;
         adc_data <= 13'h0aaa;
      end else begin
         adc_done <= 1'b0;
         adc_data <= ~adc_data;
         if (adc_start) begin
            busy_r <= 1'b1;
            wait_r <= 2'h2;
            chan_r <= adc_chan;
         end else if (busy_r && wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
         end else if (busy_r) begin
            busy_r <= 1'b0;
            adc_done <= 1'b1;
            adc_data <= {chan_r, lvl};
         end
      end
   end
   // Sync clock stands still unless enabled
   initial begin
      sync_pin = 1'b0;
      forever #62.5 if (sync_on) sync_pin = ~sync_pin;
   end
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import rsc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, er, sync_on = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic mrun = 1'b1, srun = 1'b1, wp = 1'b0, vwin = 1'b1, sync_pin;
   logic slew_tick = 1'b0, sw_cycle = 1'b0, adc_done, adc_start;
   logic [1:0] margin = 2'h1;
   logic [23:0] dly = 24'h000028;
   logic [9:0] lvl = 10'h155;
   rsc_cmp_t cmp = '0;
   logic [12:0] adc_data;
   logic [2:0] adc_chan;
   logic [8:0] ref_dac;
   logic sw_en, disc, trk, pgw, extc, valid, alert_n, fault;
   int failures = 0;
   int n_compared = 0;
   rsc_top #(.FAST_CYC(200), .SLOW_CYC(1000), .PG_MAX_CYC(100)) rsc_top_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .master_run_pin(mrun), .standby_run_pin(srun),
      .write_protect_pin(wp), .margin_pin(margin), .valid_window_pin(vwin),
      .valid_delay_pin(dly), .sync_pin, .slew_tick, .sw_cycle, .cmp,
      .adc_done, .adc_data, .adc_chan, .adc_start, .ref_dac,
      .switch_en(sw_en), .disc_mode(disc), .track_sel(trk),
      .pg_default_win(pgw), .ext_clk_sel(extc), .output_valid_flag(valid),
      .alert_n, .fault_flag(fault));
   rsc_stage_model rsc_stage_model_inst (.pclk, .presetn, .adc_start,
      .adc_chan, .adc_done, .adc_data, .lvl, .sync_on, .sync_pin);
   initial begin
      forever #5 pclk = ~pclk;
   end
   // ----
   // Shared tasks
   // ----
   task final_report;
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         failures++;
         $display("ERROR %0t bus answer timeout", $time);
         final_report;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task pulses(input int n, input bit sw);
      repeat (n) begin
         if (sw) sw_cycle <= 1'b1;
         else slew_tick <= 1'b1;
         cyc(3);
         sw_cycle <= 1'b0;
         slew_tick <= 1'b0;
         cyc(3);
      end
   endtask
   function automatic logic [31:0] tv(input logic [2:0] c, logic [9:0] l);
      return {19'h0, c, l};
   endfunction
   // ----
   // Scenarios
   // ----
   task t_margin;
      apb(1'b1, RSC_ADDR_NOMINAL, 32'h005);
      apb(1'b1, RSC_ADDR_UPPER, 32'h00a);
      apb(1'b1, RSC_ADDR_LOWER, 32'h1fd);
      cyc(5);
      pulses(5, 1'b0);
      chk(ref_dac, 32'h005);
      margin <= 2'h3;
      cyc(5);
      pulses(5, 1'b0);
      chk(ref_dac, 32'h00a);
      margin <= 2'h0;
      cyc(5);
      pulses(13, 1'b0);
      chk(ref_dac, 32'h1fd);
      margin <= 2'h1;
      cyc(5);
      pulses(8, 1'b0);
      chk(ref_dac, 32'h005);
   endtask
   task t_guard;
      wp <= 1'b1;
      cyc(5);
      apb(1'b1, RSC_ADDR_NOMINAL, 32'h030);
      rdchk(RSC_ADDR_NOMINAL, 32'h005);
      wp <= 1'b0;
      cyc(5);
      apb(1'b1, RSC_ADDR_NOMINAL, 32'h030);
      rdchk(RSC_ADDR_NOMINAL, 32'h030);
      chk(sw_en, 1);
      apb(1'b1, RSC_ADDR_CTRL, 32'h0);
      cyc(10);
      chk(sw_en, 0);
      apb(1'b1, RSC_ADDR_CTRL, 32'h1);
      srun <= 1'b0;
      cyc(10);
      chk(sw_en, 0);
      srun <= 1'b1;
      cyc(10);
      chk(sw_en, 1);
   endtask
   task t_loop;
      cmp.track_below <= 1'b1;
      cmp.ov <= 1'b1;
      cyc(10);
      chk({trk, disc}, 32'h3);
      cmp.track_below <= 1'b0;
      cyc(10);
      chk({trk, disc, fault}, 32'h1);
      cmp.ov <= 1'b0;
      apb(1'b1, RSC_ADDR_CTRL, 32'h0);
      apb(1'b1, RSC_ADDR_CTRL, 32'h1);
      cyc(10);
      chk({fault, alert_n}, 32'h1);
      vwin <= 1'b0;
      cmp.win_ok <= 1'b1;
      cyc(30);
      chk({pgw, valid}, 32'h0);
      vwin <= 1'b1;
      cyc(20);
      chk({pgw, valid}, 32'h3);
      cmp.win_ok <= 1'b0;
      pulses(12, 1'b1);
      chk(valid, 1);
      pulses(6, 1'b1);
      chk(valid, 0);
      sync_on <= 1'b1;
      cyc(40);
      chk(extc, 1);
      sync_on <= 1'b0;
      cyc(100);
      chk(extc, 0);
   endtask
   task t_telemetry;
      cyc(700);
      rdchk(RSC_ADDR_TEL, tv(3'h0, 10'h155));
      rdchk(RSC_ADDR_TEL + 8'h10, tv(3'h4, 10'h155));
      lvl <= 10'h0aa;
      cyc(700);
      rdchk(RSC_ADDR_TEL + 8'h08, tv(3'h2, 10'h0aa));
      apb(1'b1, RSC_ADDR_PEAK + 8'h04, 32'h0);
      cyc(700);
      rdchk(RSC_ADDR_PEAK, tv(3'h0, 10'h155));
      rdchk(RSC_ADDR_PEAK + 8'h04, tv(3'h1, 10'h0aa));
      apb(1'b1, RSC_ADDR_CMD, {24'h5a5a5a, RSC_PEAK_WIPE_CODE});
      cyc(700);
      rdchk(RSC_ADDR_PEAK, tv(3'h0, 10'h0aa));
      srun <= 1'b0;
      cyc(10);
      lvl <= 10'h0f0;
      cyc(2500);
      rdchk(RSC_ADDR_TEL + 8'h04, tv(3'h1, 10'h0f0));
      rdchk(RSC_ADDR_TEL + 8'h0c, tv(3'h3, 10'h0aa));
      rdchk(RSC_ADDR_NOMINAL, 32'h030);
      srun <= 1'b1;
   endtask
   task t_master;
      mrun <= 1'b0;
      cyc(10);
      chk(sw_en, 0);
      apb(1'b0, RSC_ADDR_NOMINAL, 32'h0);
      chk(er, 1);
      mrun <= 1'b1;
      cyc(10);
      chk(ref_dac, 32'h0);
      rdchk(RSC_ADDR_NOMINAL, 32'h0);
      rdchk(RSC_ADDR_CTRL, 32'h1);
      rdchk(RSC_ADDR_PEAK, 32'h0);
   endtask
   initial begin
      cyc(20);
      presetn <= 1'b1;
      cyc(2);
      rdchk(RSC_ADDR_NOMINAL, 32'h0);
      rdchk(RSC_ADDR_CTRL, 32'h1);
      apb(1'b0, 8'h1c, 32'h0);
      chk(er, 1);
      t_margin;
      t_guard;
      t_loop;
      t_telemetry;
      t_master;
      final_report;
   end
endmodule
`default_nettype wire
